// ---- btsc_consts.svh ----
// constants for the branch trace store control block
`ifndef BTSC_CONSTS_SVH
`define BTSC_CONSTS_SVH

// ==========================================
// register byte offsets
`define BTSC_CTRL_OFF 8'h00
`define BTSC_STATUS_OFF 8'h04
`define BTSC_BASE_OFF 8'h08
`define BTSC_INDEX_OFF 8'h0C
`define BTSC_ABSMAX_OFF 8'h10
`define BTSC_THRESH_OFF 8'h14

// ==========================================
// control register fields
`define BTSC_CTRL_TRACE_EN 0
`define BTSC_CTRL_STORE_SEL 1
`define BTSC_CTRL_BUF_INT_EN 2
`define BTSC_CTRL_SUP_KERNEL 3
`define BTSC_CTRL_SUP_USER 4
`define BTSC_CTRL_RESET 32'h0000_0000

// ==========================================
// status register fields
`define BTSC_ST_OVF 0
`define BTSC_ST_FULL 1
`define BTSC_ST_MASKED 2
`define BTSC_ST_CNT_OVF 3
`define BTSC_ST_PREC_OVF 4
`define BTSC_ST_BUSY 5

// ==========================================
// record layout and bus answers
`define BTSC_REC_BYTES 32'h0000_0018
`define BTSC_FIELD_BYTES 32'h0000_0008
`define BTSC_PRED_BIT 4
`define BTSC_KERNEL_LEVEL 2'h0
`define BTSC_RESP_OKAY 2'h0
`define BTSC_RESP_SLVERR 2'h2
`define BTSC_ADDR_LSB 2
`define BTSC_WORD_ZERO 32'h0000_0000

`endif

// ---- btsc_pkg.sv ----
// types shared by the branch trace store control block
package btsc_pkg;
  // ==========================================
  // record writer states
  typedef enum logic [1:0] {
    BTSC_IDLE = 2'b00,
    BTSC_SRC = 2'b01,
    BTSC_DST = 2'b10,
    BTSC_PRED = 2'b11
  } btsc_beat_type;

  typedef logic [31:0] btsc_word_type;
  typedef logic [63:0] btsc_field_type;
endpackage

// ---- btsc_record_writer.sv ----
// writes one 24-byte trace record to memory as three 8-byte beats
`timescale 1ns/1ps
`include "btsc_consts.svh"
module btsc_record_writer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire btsc_pkg::btsc_word_type start_addr,
  input wire btsc_pkg::btsc_field_type src_addr,
  input wire btsc_pkg::btsc_field_type dst_addr,
  input wire logic predicted,
  output logic busy,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output btsc_pkg::btsc_word_type mem_wr_addr,
  output btsc_pkg::btsc_field_type mem_wr_data
);
  import btsc_pkg::*;

  btsc_beat_type state_reg, state_next; // current beat
  btsc_word_type addr_reg, addr_next; // beat address
  btsc_field_type data_reg, data_next; // beat payload
  btsc_field_type dst_reg, dst_next; // held destination field
  btsc_field_type pred_reg, pred_next; // held prediction field

  // ==========================================
  // beat sequencing
  // next beat chosen only on an accepted beat, so memory may stall freely
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    dst_next = dst_reg;
    pred_next = pred_reg;
    case (state_reg)
      BTSC_IDLE: begin
        if (start) begin // source field first
          state_next = BTSC_SRC;
          addr_next = start_addr;
          data_next = src_addr;
          dst_next = dst_addr;
          pred_next = 64'h0000_0000_0000_0000;
          pred_next[`BTSC_PRED_BIT] = predicted;
        end
      end
      BTSC_SRC: begin
        if (mem_wr_ready) begin
          state_next = BTSC_DST;
          addr_next = addr_reg + `BTSC_FIELD_BYTES;
          data_next = dst_reg;
        end
      end
      BTSC_DST: begin
        if (mem_wr_ready) begin
          state_next = BTSC_PRED;
          addr_next = addr_reg + `BTSC_FIELD_BYTES;
          data_next = pred_reg;
        end
      end
      BTSC_PRED: begin
        if (mem_wr_ready) begin
          state_next = BTSC_IDLE;
        end
      end
      default: begin
        state_next = BTSC_IDLE;
      end
    endcase
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= BTSC_IDLE;
      addr_reg <= 32'h0000_0000;
      data_reg <= 64'h0000_0000_0000_0000;
      dst_reg <= 64'h0000_0000_0000_0000;
      pred_reg <= 64'h0000_0000_0000_0000;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      dst_reg <= dst_next;
      pred_reg <= pred_next;
    end
  end

  assign busy = (state_reg != BTSC_IDLE);
  assign mem_wr_valid = (state_reg != BTSC_IDLE);
  assign mem_wr_addr = addr_reg;
  assign mem_wr_data = data_reg;
endmodule

// ---- btsc_top.sv ----
// branch trace store control: message routing, buffer index and interrupt
// How it works
// - trace enable off: no messages at all
// - store select picks bus or buffer
// - a message goes to one destination only
// - interrupt enable set; clear means circular buffer
// - flag overflow when index reaches threshold
// - threshold above maximum suppresses buffer overflow interrupts
// - kernel suppress stores only privilege above zero
// - user suppress stores only privilege zero
// - both suppress flags: generate, store nothing
// - no suppress stores all; interrupt on threshold whether enabled or not
// - all overflow sources share one interrupt
// - full non-circular buffer stays enabled
// - interrupt masks itself until software clears
// - records are three 8-byte fields
`timescale 1ns/1ps
`include "btsc_consts.svh"
module btsc_top (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // taken branches from the core
  input wire logic branch_message_valid,
  output logic branch_message_ready,
  input wire btsc_pkg::btsc_field_type branch_from,
  input wire btsc_pkg::btsc_field_type branch_to,
  input wire logic branch_predicted,
  input wire logic [1:0] privilege_level,
  // messages sent out on the system bus
  output logic bus_msg_valid,
  input wire logic bus_msg_ready,
  output btsc_pkg::btsc_field_type bus_msg_from,
  output btsc_pkg::btsc_field_type bus_msg_to,
  // record writes into memory
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output btsc_pkg::btsc_word_type mem_wr_addr,
  output btsc_pkg::btsc_field_type mem_wr_data,
  // other overflow sources sharing the vector
  input wire logic counter_overflow,
  input wire logic precise_sampling_overflow,
  output logic perf_monitor_interrupt
);
  import btsc_pkg::*;

  // ==========================================
  // helpers
  // true when a whole record fits below the absolute maximum
  function automatic logic rec_fits(input btsc_word_type idx, input btsc_word_type lim);
    rec_fits = ((idx + `BTSC_REC_BYTES) <= lim);
  endfunction

  // ==========================================
  // state
  btsc_word_type ctrl_reg, ctrl_next; // control flags
  btsc_word_type base_reg, base_next; // buffer base
  btsc_word_type index_reg, index_next; // buffer write index
  btsc_word_type absmax_reg, absmax_next; // absolute maximum
  btsc_word_type thresh_reg, thresh_next; // interrupt threshold
  logic ovf_reg, ovf_next; // sticky buffer overflow
  logic masked_reg, masked_next; // interrupt masked after taken
  logic irq_reg, irq_next; // interrupt pulse
  logic aw_held_reg, aw_held_next; // write address captured
  logic w_held_reg, w_held_next; // write data captured
  logic [7:0] awaddr_reg, awaddr_next;
  btsc_word_type wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  btsc_word_type rdata_reg, rdata_next;
  logic busmsg_reg, busmsg_next; // bus message pending
  btsc_field_type busfrom_reg, busfrom_next;
  btsc_field_type busto_reg, busto_next;

  logic trace_enable, trace_store_select, buffer_interrupt_enable;
  logic suppress_kernel_records, suppress_user_records;
  logic writer_busy; // record writer occupied
  logic accept; // branch taken this cycle
  logic filter_pass; // privilege filter verdict
  logic buffer_full; // next record would not fit
  logic store_start; // record write begins
  logic do_write; // register write commits
  btsc_word_type adv_index; // index after one record
  btsc_word_type merged; // write data merged under strobes
  btsc_word_type status_word;

  assign trace_enable = ctrl_reg[`BTSC_CTRL_TRACE_EN];
  assign trace_store_select = ctrl_reg[`BTSC_CTRL_STORE_SEL];
  assign buffer_interrupt_enable = ctrl_reg[`BTSC_CTRL_BUF_INT_EN];
  assign suppress_kernel_records = ctrl_reg[`BTSC_CTRL_SUP_KERNEL];
  assign suppress_user_records = ctrl_reg[`BTSC_CTRL_SUP_USER];

  // ==========================================
  // message routing
  // one message at a time: simpler than a queue, costs core stalls
  assign branch_message_ready = !writer_busy && !busmsg_reg;
  assign accept = branch_message_valid && branch_message_ready;
  // level zero is kernel; both suppress flags together drop everything
  assign filter_pass = (privilege_level == `BTSC_KERNEL_LEVEL) ?
                       !suppress_kernel_records : !suppress_user_records;
  assign buffer_full = !rec_fits(index_reg, absmax_reg);
  assign adv_index = index_reg + `BTSC_REC_BYTES;
  // full buffer in interrupt mode drops records but stays enabled
  assign store_start = accept && trace_enable && trace_store_select && filter_pass &&
                       !(buffer_interrupt_enable && buffer_full);

  // bus message register
  always_comb begin
    busmsg_next = busmsg_reg;
    busfrom_next = busfrom_reg;
    busto_next = busto_reg;
    if (busmsg_reg && bus_msg_ready) begin
      busmsg_next = 1'b0;
    end
    if (accept && trace_enable && !trace_store_select) begin
      busmsg_next = 1'b1;
      busfrom_next = branch_from;
      busto_next = branch_to;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busmsg_reg <= 1'b0;
      busfrom_reg <= 64'h0000_0000_0000_0000;
      busto_reg <= 64'h0000_0000_0000_0000;
    end else begin
      busmsg_reg <= busmsg_next;
      busfrom_reg <= busfrom_next;
      busto_reg <= busto_next;
    end
  end

  assign bus_msg_valid = busmsg_reg;
  assign bus_msg_from = busfrom_reg;
  assign bus_msg_to = busto_reg;

  // ==========================================
  // record writer
  btsc_record_writer u_writer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(store_start),
    .start_addr(index_reg),
    .src_addr(branch_from),
    .dst_addr(branch_to),
    .predicted(branch_predicted),
    .busy(writer_busy),
    .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data)
  );

  // ==========================================
  // axi4-lite write channel
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  always_comb begin
    merged = `BTSC_WORD_ZERO;
    case (awaddr_reg)
      `BTSC_CTRL_OFF: merged = ctrl_reg;
      `BTSC_BASE_OFF: merged = base_reg;
      `BTSC_INDEX_OFF: merged = index_reg;
      `BTSC_ABSMAX_OFF: merged = absmax_reg;
      `BTSC_THRESH_OFF: merged = thresh_reg;
      default: merged = `BTSC_WORD_ZERO;
    endcase
    for (int b = 0; b < 4; b++) begin
      if (wstrb_reg[b]) begin
        merged[8*b +: 8] = wdata_reg[8*b +: 8];
      end
    end
  end

  // address and data taken in either order, answer once both are held
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      case (awaddr_reg)
        `BTSC_CTRL_OFF, `BTSC_STATUS_OFF, `BTSC_BASE_OFF, `BTSC_INDEX_OFF,
        `BTSC_ABSMAX_OFF, `BTSC_THRESH_OFF: bresp_next = `BTSC_RESP_OKAY;
        default: bresp_next = `BTSC_RESP_SLVERR; // unmapped
      endcase
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ==========================================
  // control, management area and index
  // software write to the index beats a same-cycle advance, so a rewind
  // is never lost; the advance that loses is simply overwritten
  always_comb begin
    ctrl_next = ctrl_reg;
    base_next = base_reg;
    index_next = index_reg;
    absmax_next = absmax_reg;
    thresh_next = thresh_reg;
    if (store_start) begin
      index_next = adv_index;
      if (!buffer_interrupt_enable && !rec_fits(adv_index, absmax_reg)) begin
        index_next = base_reg;
      end
    end
    if (do_write) begin
      case (awaddr_reg)
        `BTSC_CTRL_OFF: ctrl_next = merged;
        `BTSC_BASE_OFF: base_next = merged;
        `BTSC_INDEX_OFF: index_next = merged;
        `BTSC_ABSMAX_OFF: absmax_next = merged;
        `BTSC_THRESH_OFF: thresh_next = merged;
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `BTSC_CTRL_RESET;
      base_reg <= 32'h0000_0000;
      index_reg <= 32'h0000_0000;
      absmax_reg <= 32'h0000_0000;
      thresh_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      base_reg <= base_next;
      index_reg <= index_next;
      absmax_reg <= absmax_next;
      thresh_reg <= thresh_next;
    end
  end

  // ==========================================
  // overflow flag and shared interrupt
  // threshold compare runs whatever the enable; only a threshold above the
  // maximum keeps a circular buffer quiet
  always_comb begin
    ovf_next = ovf_reg;
    masked_next = masked_reg;
    if (do_write && (awaddr_reg == `BTSC_STATUS_OFF)) begin // write one to clear
      if (wstrb_reg[0] && wdata_reg[`BTSC_ST_OVF]) begin
        ovf_next = 1'b0;
      end
      if (wstrb_reg[0] && wdata_reg[`BTSC_ST_MASKED]) begin
        masked_next = 1'b0;
      end
    end
    if (store_start && (adv_index >= thresh_reg)) begin
      ovf_next = 1'b1;
    end
    if (irq_reg) begin
      masked_next = 1'b1;
    end
    irq_next = (ovf_reg || counter_overflow || precise_sampling_overflow) &&
               !masked_reg && !irq_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_reg <= 1'b0;
      masked_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
      masked_reg <= masked_next;
      irq_reg <= irq_next;
    end
  end

  assign perf_monitor_interrupt = irq_reg;

  // ==========================================
  // axi4-lite read channel
  always_comb begin
    status_word = `BTSC_WORD_ZERO;
    status_word[`BTSC_ST_OVF] = ovf_reg;
    status_word[`BTSC_ST_FULL] = buffer_full;
    status_word[`BTSC_ST_MASKED] = masked_reg;
    status_word[`BTSC_ST_CNT_OVF] = counter_overflow;
    status_word[`BTSC_ST_PREC_OVF] = precise_sampling_overflow;
    status_word[`BTSC_ST_BUSY] = writer_busy;
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `BTSC_RESP_OKAY;
      case (s_axi_araddr)
        `BTSC_CTRL_OFF: rdata_next = ctrl_reg;
        `BTSC_STATUS_OFF: rdata_next = status_word;
        `BTSC_BASE_OFF: rdata_next = base_reg;
        `BTSC_INDEX_OFF: rdata_next = index_reg;
        `BTSC_ABSMAX_OFF: rdata_next = absmax_reg;
        `BTSC_THRESH_OFF: rdata_next = thresh_reg;
        default: begin
          rdata_next = `BTSC_WORD_ZERO;
          rresp_next = `BTSC_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
endmodule

// ---- btsc_top_properties.sv ----
// concurrent checks on the ports of the branch trace store control top
`timescale 1ns/1ps
module btsc_top_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic branch_message_ready,
  input wire logic bus_msg_valid,
  input wire logic bus_msg_ready,
  input wire btsc_pkg::btsc_field_type bus_msg_from,
  input wire btsc_pkg::btsc_field_type bus_msg_to,
  input wire logic mem_wr_valid,
  input wire logic mem_wr_ready,
  input wire btsc_pkg::btsc_word_type mem_wr_addr,
  input wire btsc_pkg::btsc_field_type mem_wr_data,
  input wire logic perf_monitor_interrupt
);
  import btsc_pkg::*;
  // ==========================================
  // beat tracking
  logic [1:0] beat_reg, beat_next; // beats of the record already taken
  btsc_word_type first_reg, first_next; // address of the record's first beat
  // count handshakes; a record is always three beats
  always_comb begin
    beat_next = beat_reg;
    first_next = first_reg;
    if (mem_wr_valid && mem_wr_ready) begin
      beat_next = (beat_reg == 2'h2) ? 2'h0 : beat_reg + 2'h1;
      if (beat_reg == 2'h0) first_next = mem_wr_addr;
    end
  end
  // register only; reset drops any half-seen record
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beat_reg <= 2'h0;
      first_reg <= 32'h0000_0000;
    end else begin
      beat_reg <= beat_next;
      first_reg <= first_next;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_one_dest: assert property (!(bus_msg_valid && mem_wr_valid))
    else $error("bus message and buffer write at once");
  a_busy_gate: assert property (bus_msg_valid || mem_wr_valid |-> !branch_message_ready)
    else $error("new branch taken while a delivery is pending");
  a_bus_hold: assert property (bus_msg_valid && !bus_msg_ready |=>
    bus_msg_valid && $stable({bus_msg_from, bus_msg_to}))
    else $error("bus message changed before it was taken");
  a_beat_hold: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("record beat changed before it was taken");
  a_beat_next: assert property (mem_wr_valid && mem_wr_ready && beat_reg != 2'h2 |=> mem_wr_valid)
    else $error("record beat missing");
  a_beat_addr: assert property (mem_wr_valid && beat_reg != 2'h0 |->
    mem_wr_addr == first_reg + {27'h0, beat_reg, 3'h0})
    else $error("record beat at wrong address");
  a_pred_word: assert property (mem_wr_valid && beat_reg == 2'h2 |->
    (mem_wr_data & ~64'h0000_0000_0000_0010) == 64'h0000_0000_0000_0000)
    else $error("prediction word has stray bits");
  a_irq_pulse: assert property (perf_monitor_interrupt |=> !perf_monitor_interrupt)
    else $error("interrupt not masked after one pulse");
endmodule
bind btsc_top btsc_top_properties u_props (.*);

// ---- btsc_mem_model.sv ----
// far side model: trace buffer memory and system bus message sink
`timescale 1ns/1ps
module btsc_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_wr_valid,
  output logic mem_wr_ready,
  input wire btsc_pkg::btsc_word_type mem_wr_addr,
  input wire btsc_pkg::btsc_field_type mem_wr_data,
  input wire logic bus_msg_valid,
  output logic bus_msg_ready,
  input wire btsc_pkg::btsc_field_type bus_msg_from,
  input wire btsc_pkg::btsc_field_type bus_msg_to
);
  import btsc_pkg::*;
  logic [95:0] wlog[$]; // this core's own buffer, address over data
  logic [127:0] blog[$]; // taken bus messages
  // random stalls so the design must hold every beat and message
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_wr_ready <= 1'b0;
      bus_msg_ready <= 1'b0;
    end else begin
      if (mem_wr_valid && mem_wr_ready) wlog.push_back({mem_wr_addr, mem_wr_data});
      if (bus_msg_valid && bus_msg_ready) blog.push_back({bus_msg_from, bus_msg_to});
      mem_wr_ready <= ($urandom % 3) != 0;
      bus_msg_ready <= ($urandom % 3) != 0;
    end
  end
endmodule

// ---- tb_branch_trace_store_ctl.sv ----
// self-checking bench for the branch trace store control block
`timescale 1ns/1ps
`include "btsc_consts.svh"
module tb_branch_trace_store_ctl;
  import btsc_pkg::*;
  // ==========================================
  // design inputs, all valued at time zero
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF; // full words only
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, branch_message_valid = 1'b0;
  logic branch_predicted = 1'b0, counter_overflow = 1'b0, precise_sampling_overflow = 1'b0;
  logic [1:0] privilege_level = 2'h0;
  btsc_field_type branch_from = '0, branch_to = '0;
  // design outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic branch_message_ready, bus_msg_valid, bus_msg_ready, mem_wr_valid, mem_wr_ready;
  logic perf_monitor_interrupt;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_v;
  btsc_field_type bus_msg_from, bus_msg_to, mem_wr_data;
  btsc_word_type mem_wr_addr;
  int err_total = 0, n_checks = 0, irq_n = 0;
  always #20 aclk = ~aclk;
  btsc_top dut (.*);
  btsc_mem_model pm (.*);
  // count interrupt pulses
  always @(posedge aclk) begin
    if (perf_monitor_interrupt === 1'b1) irq_n <= irq_n + 1;
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // axi-lite write: address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // one random branch at the given privilege level
  task automatic send(input logic [1:0] p);
    @(posedge aclk);
    branch_from <= {$urandom, $urandom};
    branch_to <= {$urandom, $urandom};
    branch_predicted <= 1'($urandom % 2);
    privilege_level <= p;
    branch_message_valid <= 1'b1;
    do @(posedge aclk); while (!branch_message_ready);
    branch_message_valid <= 1'b0;
  endtask
  // wait until no delivery is pending
  task automatic settle;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (n < 4 || !(branch_message_ready && !mem_wr_valid && !bus_msg_valid));
  endtask
  // expect exactly one record at address a
  task automatic chk_rec(input logic [31:0] a);
    chk(pm.wlog.size(), 3);
    if (pm.wlog.size() == 3) begin
      chk(pm.wlog[0], {a, branch_from});
      chk(pm.wlog[1], {a + 32'h0000_0008, branch_to});
      chk(pm.wlog[2], {a + 32'h0000_0010, 59'h0, branch_predicted, 4'h0});
    end
    pm.wlog.delete();
  endtask
  function automatic logic kept(input logic sk, input logic su, input logic [1:0] p);
    return !(sk && p == `BTSC_KERNEL_LEVEL) && !(su && p != `BTSC_KERNEL_LEVEL);
  endfunction
  // ==========================================
  // watchdog: 10,000 cycles
  initial begin
    #400000;
    err_total++;
    give_verdict;
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(11));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // all registers reset to zero; unmapped place refused
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      chk(rd_v, i == 1 ? 32'h0000_0002 : 32'h0); // zero maximum reads as full
    end
    rd(8'h40);
    chk({rd_v, resp}, {32'h0, `BTSC_RESP_SLVERR});
    wr(8'h40, 32'hFFFF_FFFF);
    chk(resp, `BTSC_RESP_SLVERR);
    // trace off: nothing anywhere whatever the other flags
    wr(`BTSC_CTRL_OFF, 32'h0000_001E);
    send(2'h0);
    settle;
    chk(pm.wlog.size() + pm.blog.size(), 0);
    // store select clear: messages go out on the bus only
    for (int i = 0; i < 2; i++) begin
      wr(`BTSC_CTRL_OFF, i ? 32'h0000_001D : 32'h0000_0001);
      send(2'($urandom));
      settle;
      chk(pm.blog.size(), 1);
      if (pm.blog.size() == 1) chk(pm.blog[0], {branch_from, branch_to});
      chk(pm.wlog.size(), 0);
      pm.blog.delete();
    end
    // circular buffer of two records; threshold above maximum
    wr(`BTSC_BASE_OFF, 32'h0000_0100);
    wr(`BTSC_INDEX_OFF, 32'h0000_0100);
    wr(`BTSC_ABSMAX_OFF, 32'h0000_0131);
    wr(`BTSC_THRESH_OFF, 32'h0000_0200);
    wr(`BTSC_CTRL_OFF, 32'h0000_0003);
    for (int k = 0; k < 3; k++) begin
      send(2'($urandom));
      settle;
      chk_rec(k == 1 ? 32'h0000_0118 : 32'h0000_0100);
    end
    rd(`BTSC_STATUS_OFF);
    chk({rd_v[0], 32'(irq_n)}, {1'b0, 32'h0});
    // privilege filter, every suppress combination, kernel and user levels
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 2; j++) begin
        wr(`BTSC_CTRL_OFF, 32'h0000_0003 | (32'(c) << 3));
        wr(`BTSC_INDEX_OFF, 32'h0000_0100);
        send(j ? 2'(1 + $urandom % 3) : 2'h0);
        settle;
        if (kept(c[0], c[1], privilege_level)) chk_rec(32'h0000_0100);
        else chk(pm.wlog.size(), 0);
      end
    end
    // interrupt mode: threshold reached by the first record
    wr(`BTSC_INDEX_OFF, 32'h0000_0100);
    wr(`BTSC_THRESH_OFF, 32'h0000_0118);
    wr(`BTSC_CTRL_OFF, 32'h0000_0007);
    send(2'h0);
    settle;
    chk_rec(32'h0000_0100);
    chk(irq_n, 1);
    rd(`BTSC_STATUS_OFF);
    chk(rd_v[2:0], 3'b101);
    // masked: a counter overflow raises nothing until the mask is cleared
    counter_overflow <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(irq_n, 1);
    wr(`BTSC_CTRL_OFF, 32'h0000_0006);
    wr(`BTSC_STATUS_OFF, 32'h0000_0005);
    wr(`BTSC_CTRL_OFF, 32'h0000_0007);
    repeat (4) @(posedge aclk);
    chk(irq_n, 2);
    rd(`BTSC_STATUS_OFF);
    chk(rd_v[3], 1'b1);
    counter_overflow <= 1'b0;
    precise_sampling_overflow <= 1'b1;
    wr(`BTSC_STATUS_OFF, 32'h0000_0004);
    repeat (4) @(posedge aclk);
    chk(irq_n, 3);
    precise_sampling_overflow <= 1'b0;
    // second record fills the buffer; the third is dropped, settings kept
    send(2'h0);
    settle;
    chk_rec(32'h0000_0118);
    send(2'h0);
    settle;
    chk(pm.wlog.size(), 0);
    rd(`BTSC_CTRL_OFF);
    chk(rd_v, 32'h0000_0007);
    give_verdict;
  end
endmodule
